// ---- design/asu_pkg.sv ----
// constants, field layouts and state types of the asynchronous serial uart
package asu_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_DATA    = 8'h00;
  localparam logic [7:0] OFS_IEN     = 8'h04;
  localparam logic [7:0] OFS_ISTAT   = 8'h08;
  localparam logic [7:0] OFS_LCTL    = 8'h0C;
  localparam logic [7:0] OFS_MCTL    = 8'h10;
  localparam logic [7:0] OFS_LSTAT   = 8'h14;
  localparam logic [7:0] OFS_MSTAT   = 8'h18;
  localparam logic [7:0] OFS_SCRATCH = 8'h1C;
  localparam logic [7:0] OFS_DIV_LO  = 8'h20;
  localparam logic [7:0] OFS_DIV_HI  = 8'h24;
  // line control fields
  localparam int LC_WLS_LO = 0;
  localparam int LC_STB    = 2;
  localparam int LC_PEN    = 3;
  localparam int LC_EPS    = 4;
  localparam int LC_STICK  = 5;
  localparam int LC_BREAK  = 6;
  // modem control fields
  localparam int MC_DTR  = 0;
  localparam int MC_RTS  = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  // interrupt source bits, also the enable bits
  localparam int IS_RXRDY = 0;
  localparam int IS_THRE  = 1;
  localparam int IS_OVR   = 2;
  localparam int IS_PAR   = 3;
  localparam int IS_FRM   = 4;
  localparam int IS_BRK   = 5;
  localparam int IS_DCTS  = 6;
  localparam int IS_DDSR  = 7;
  localparam int IS_TERI  = 8;
  localparam int IS_DDCD  = 9;
  localparam int NUM_IRQ  = 10;
  // synchronised pin vector layout
  localparam int PIN_RCLK = 0;
  localparam int PIN_SIN  = 1;
  localparam int PIN_CTS  = 2;
  localparam int PIN_DSR  = 3;
  localparam int PIN_RI   = 4;
  localparam int PIN_DCD  = 5;
  localparam int NUM_PIN  = 6;
  // reset values
  localparam logic [7:0]  LCTL_RST = 8'h03;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  // oversampling counts: half bit to the centre, then a whole bit
  localparam logic [3:0] SUB_HALF = 4'h7;
  localparam logic [3:0] SUB_LAST = 4'hF;

  typedef enum logic [2:0] {
    ASU_IDLE, ASU_START, ASU_DATA, ASU_PAR, ASU_STOP
  } asu_frame_e;
endpackage : asu_pkg

// ---- design/asu_uart.sv ----
// asynchronous serial uart with apb register access
`timescale 1ns/100ps
module asu_uart (
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        apb_psel_in,
  input  wire logic        apb_penable_in,
  input  wire logic        apb_pwrite_in,
  input  wire logic [7:0]  apb_paddr_in,
  input  wire logic [31:0] apb_pwdata_in,
  output logic      [31:0] apb_prdata_out,
  output logic             apb_pready_out,
  output logic             apb_pslverr_out,
  input  wire logic        serial_in,
  input  wire logic        rx_clock_in,
  input  wire logic        carrier_detect_n_in,
  input  wire logic        ring_indicator_n_in,
  input  wire logic        data_set_ready_n_in,
  input  wire logic        clear_to_send_n_in,
  output logic             serial_out,
  output logic             baud_clock_out_n,
  output logic             request_to_send_n_out,
  output logic             terminal_ready_n_out,
  output logic             general_output_one_n_out,
  output logic             general_output_two_n_out,
  output logic             irq_out
);
  // ------------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------------
  function automatic logic [7:0] len_mask(input logic [1:0] wls);
    len_mask = 8'hFF >> (2'h3 - wls);
  endfunction : len_mask

  // even parity when eps is set; stick forces the bit to not eps
  function automatic logic par_of(input logic [7:0] d, input logic [7:0] lc);
    logic x;
    x = ^(d & len_mask(lc[1:0]));
    par_of = lc[asu_pkg::LC_STICK] ? ~lc[asu_pkg::LC_EPS]
                                   : (x ^ ~lc[asu_pkg::LC_EPS]);
  endfunction : par_of

  // ------------------------------------------------------------------
  // pin synchronisers: three stages, a change counts once 2 and 3 agree
  // ------------------------------------------------------------------
  logic [asu_pkg::NUM_PIN-1:0] pin_raw;
  logic [asu_pkg::NUM_PIN-1:0] pin_s1_r;
  logic [asu_pkg::NUM_PIN-1:0] pin_s2_r;
  logic [asu_pkg::NUM_PIN-1:0] pin_s3_r;
  logic [asu_pkg::NUM_PIN-1:0] pin_r;
  assign pin_raw = {carrier_detect_n_in, ring_indicator_n_in,
                    data_set_ready_n_in, clear_to_send_n_in,
                    serial_in, rx_clock_in};
  genvar gi;
  generate
    for (gi = 0; gi < asu_pkg::NUM_PIN; gi++) begin : g_sync
      always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          pin_s1_r[gi] <= 1'b1;
          pin_s2_r[gi] <= 1'b1;
          pin_s3_r[gi] <= 1'b1;
          pin_r[gi]    <= 1'b1;
        end else begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
          pin_s3_r[gi] <= pin_s2_r[gi];
          if (pin_s2_r[gi] == pin_s3_r[gi]) begin
            pin_r[gi] <= pin_s3_r[gi];
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [7:0]  lctl_r, mctl_r, scratch_r, thr_r, rbuf_r;
  logic [9:0]  ien_r;
  logic [15:0] div_r, div_cnt_r;
  logic        thr_full_r, dr_r, ovr_r, perr_r, ferr_r, brk_r;
  logic [3:0]  mdelta_r, mprev_r;
  logic        loop;
  assign loop = mctl_r[asu_pkg::MC_LOOP];

  // ------------------------------------------------------------------
  // apb slave: one wait state, pready and prdata from flops
  // ------------------------------------------------------------------
  logic        acc, done, wr_done, rd_done, addr_ok;
  logic [31:0] rd_mux;
  logic [7:0]  lstat, mstat;
  logic [9:0]  pend;
  assign acc     = apb_psel_in & apb_penable_in;
  assign done    = acc & apb_pready_out;
  assign wr_done = done & apb_pwrite_in;
  assign rd_done = done & ~apb_pwrite_in;
  assign addr_ok = (apb_paddr_in <= asu_pkg::OFS_DIV_HI) &
                   (apb_paddr_in[1:0] == 2'h0);

  logic wr_data, wr_ien, wr_lctl, wr_mctl, wr_scr, wr_dlo, wr_dhi;
  logic rd_data, rd_lstat, rd_mstat;
  assign wr_data  = wr_done & (apb_paddr_in == asu_pkg::OFS_DATA);
  assign wr_ien   = wr_done & (apb_paddr_in == asu_pkg::OFS_IEN);
  assign wr_lctl  = wr_done & (apb_paddr_in == asu_pkg::OFS_LCTL);
  assign wr_mctl  = wr_done & (apb_paddr_in == asu_pkg::OFS_MCTL);
  assign wr_scr   = wr_done & (apb_paddr_in == asu_pkg::OFS_SCRATCH);
  assign wr_dlo   = wr_done & (apb_paddr_in == asu_pkg::OFS_DIV_LO);
  assign wr_dhi   = wr_done & (apb_paddr_in == asu_pkg::OFS_DIV_HI);
  assign rd_data  = rd_done & (apb_paddr_in == asu_pkg::OFS_DATA);
  assign rd_lstat = rd_done & (apb_paddr_in == asu_pkg::OFS_LSTAT);
  assign rd_mstat = rd_done & (apb_paddr_in == asu_pkg::OFS_MSTAT);

  always_comb begin
    unique case (apb_paddr_in)
      asu_pkg::OFS_DATA:    rd_mux = {24'h000000, rbuf_r};
      asu_pkg::OFS_IEN:     rd_mux = {22'h000000, ien_r};
      asu_pkg::OFS_ISTAT:   rd_mux = {22'h000000, pend};
      asu_pkg::OFS_LCTL:    rd_mux = {24'h000000, lctl_r};
      asu_pkg::OFS_MCTL:    rd_mux = {24'h000000, mctl_r};
      asu_pkg::OFS_LSTAT:   rd_mux = {24'h000000, lstat};
      asu_pkg::OFS_MSTAT:   rd_mux = {24'h000000, mstat};
      asu_pkg::OFS_SCRATCH: rd_mux = {24'h000000, scratch_r};
      asu_pkg::OFS_DIV_LO:  rd_mux = {24'h000000, div_r[7:0]};
      asu_pkg::OFS_DIV_HI:  rd_mux = {24'h000000, div_r[15:8]};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      apb_pready_out  <= 1'b0;
      apb_prdata_out  <= 32'h00000000;
      apb_pslverr_out <= 1'b0;
    end else begin
      apb_pready_out  <= acc & ~apb_pready_out;
      apb_prdata_out  <= rd_mux;
      apb_pslverr_out <= acc & ~apb_pready_out & ~addr_ok;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lctl_r    <= asu_pkg::LCTL_RST;
      mctl_r    <= 8'h00;
      scratch_r <= 8'h00;
      ien_r     <= 10'h000;
      div_r     <= asu_pkg::DIV_RST;
    end else begin
      if (wr_lctl) lctl_r <= apb_pwdata_in[7:0];
      if (wr_mctl) mctl_r <= {3'h0, apb_pwdata_in[4:0]};
      if (wr_scr)  scratch_r <= apb_pwdata_in[7:0];
      if (wr_ien)  ien_r <= apb_pwdata_in[9:0];
      if (wr_dlo)  div_r[7:0] <= apb_pwdata_in[7:0];
      if (wr_dhi)  div_r[15:8] <= apb_pwdata_in[7:0];
    end
  end

  // ------------------------------------------------------------------
  // baud generator: tick is the 16x clock, zero divisor acts as one
  // ------------------------------------------------------------------
  logic baud_tick;
  assign baud_tick = (div_cnt_r <= 16'h0001);
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_r        <= asu_pkg::DIV_RST;
      baud_clock_out_n <= 1'b1;
    end else begin
      div_cnt_r        <= baud_tick ? div_r : div_cnt_r - 16'h0001;
      baud_clock_out_n <= ~baud_tick;
    end
  end

  // ------------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------------
  asu_pkg::asu_frame_e tx_st_r, tx_st_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_sub_r;
  logic [2:0] tx_idx_r, tx_idx_nxt;
  logic       tx_bit_r, tx_bit_nxt, tx_stop2_r, tx_stop2_nxt;
  logic       tx_load, tx_bit_end, tx_par_r;
  assign tx_load    = (tx_st_r == asu_pkg::ASU_IDLE) & thr_full_r;
  assign tx_bit_end = baud_tick & (tx_sub_r == asu_pkg::SUB_LAST);

  always_comb begin
    tx_st_nxt    = tx_st_r;
    tx_sh_nxt    = tx_sh_r;
    tx_idx_nxt   = tx_idx_r;
    tx_bit_nxt   = tx_bit_r;
    tx_stop2_nxt = tx_stop2_r;
    if (tx_load) begin
      tx_st_nxt  = asu_pkg::ASU_START;
      tx_sh_nxt  = thr_r;
      tx_bit_nxt = 1'b0;
    end else if (tx_bit_end) begin
      unique case (tx_st_r)
        asu_pkg::ASU_IDLE: tx_bit_nxt = 1'b1;
        asu_pkg::ASU_START: begin
          tx_st_nxt  = asu_pkg::ASU_DATA;
          tx_bit_nxt = tx_sh_r[0];
          tx_idx_nxt = 3'h0;
        end
        asu_pkg::ASU_DATA: begin
          if (tx_idx_r == {1'b1, lctl_r[1:0]}) begin
            tx_st_nxt    = lctl_r[asu_pkg::LC_PEN] ? asu_pkg::ASU_PAR
                                                   : asu_pkg::ASU_STOP;
            tx_bit_nxt   = lctl_r[asu_pkg::LC_PEN] ? tx_par_r : 1'b1;
            tx_stop2_nxt = lctl_r[asu_pkg::LC_STB];
          end else begin
            tx_sh_nxt  = tx_sh_r >> 1;
            tx_bit_nxt = tx_sh_r[1];
            tx_idx_nxt = tx_idx_r + 3'h1;
          end
        end
        asu_pkg::ASU_PAR: begin
          tx_st_nxt  = asu_pkg::ASU_STOP;
          tx_bit_nxt = 1'b1;
        end
        asu_pkg::ASU_STOP: begin
          tx_stop2_nxt = 1'b0;
          if (!tx_stop2_r) tx_st_nxt = asu_pkg::ASU_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_st_r    <= asu_pkg::ASU_IDLE;
      tx_sh_r    <= 8'h00;
      tx_idx_r   <= 3'h0;
      tx_bit_r   <= 1'b1;
      tx_stop2_r <= 1'b0;
      tx_sub_r   <= 4'h0;
      tx_par_r   <= 1'b0;
      thr_r      <= 8'h00;
      thr_full_r <= 1'b0;
      serial_out <= 1'b1;
    end else begin
      tx_st_r    <= tx_st_nxt;
      tx_sh_r    <= tx_sh_nxt;
      tx_idx_r   <= tx_idx_nxt;
      tx_bit_r   <= tx_bit_nxt;
      tx_stop2_r <= tx_stop2_nxt;
      tx_sub_r   <= tx_load ? 4'h0 : tx_sub_r + {3'h0, baud_tick};
      if (tx_load) tx_par_r <= par_of(thr_r, lctl_r);
      if (wr_data) thr_r <= apb_pwdata_in[7:0];
      thr_full_r <= wr_data | (thr_full_r & ~tx_load);
      serial_out <= loop | (tx_bit_r & ~lctl_r[asu_pkg::LC_BREAK]);
    end
  end

  // ------------------------------------------------------------------
  // receiver: glitch filter, centre sampling, checks
  // ------------------------------------------------------------------
  asu_pkg::asu_frame_e rx_st_r, rx_st_nxt;
  logic       rx_tick, rx_raw, rx_samp_r, rx_filt_r, rclk_prev_r;
  logic [3:0] rx_cnt_r, rx_cnt_nxt;
  logic [2:0] rx_idx_r, rx_idx_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt, rx_word;
  logic       rx_pbit_r, rx_pbit_nxt, rx_done, rx_mid;
  // loop-back borrows the baud tick because no receive clock is looped
  assign rx_tick = loop ? baud_tick
                        : (pin_r[asu_pkg::PIN_RCLK] & ~rclk_prev_r);
  assign rx_raw  = loop ? tx_bit_r : pin_r[asu_pkg::PIN_SIN];
  assign rx_mid  = (rx_cnt_r == asu_pkg::SUB_LAST);
  assign rx_word = rx_sh_r >> (2'h3 - lctl_r[1:0]);
  assign rx_done = rx_tick & rx_mid & (rx_st_r == asu_pkg::ASU_STOP);

  always_comb begin
    rx_st_nxt   = rx_st_r;
    rx_cnt_nxt  = rx_cnt_r + 4'h1;
    rx_idx_nxt  = rx_idx_r;
    rx_sh_nxt   = rx_sh_r;
    rx_pbit_nxt = rx_pbit_r;
    unique case (rx_st_r)
      asu_pkg::ASU_IDLE: begin
        rx_cnt_nxt = 4'h0;
        if (!rx_filt_r) rx_st_nxt = asu_pkg::ASU_START;
      end
      asu_pkg::ASU_START: begin
        if (rx_cnt_r == asu_pkg::SUB_HALF) begin
          rx_cnt_nxt = 4'h0;
          rx_idx_nxt = 3'h0;
          rx_st_nxt  = rx_filt_r ? asu_pkg::ASU_IDLE : asu_pkg::ASU_DATA;
        end
      end
      asu_pkg::ASU_DATA: begin
        if (rx_mid) begin
          rx_sh_nxt  = {rx_filt_r, rx_sh_r[7:1]};
          rx_idx_nxt = rx_idx_r + 3'h1;
          if (rx_idx_r == {1'b1, lctl_r[1:0]}) begin
            rx_st_nxt = lctl_r[asu_pkg::LC_PEN] ? asu_pkg::ASU_PAR
                                                : asu_pkg::ASU_STOP;
          end
        end
      end
      asu_pkg::ASU_PAR: begin
        if (rx_mid) begin
          rx_pbit_nxt = rx_filt_r;
          rx_st_nxt   = asu_pkg::ASU_STOP;
        end
      end
      asu_pkg::ASU_STOP: begin
        if (rx_mid) rx_st_nxt = asu_pkg::ASU_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rclk_prev_r <= 1'b1;
      rx_samp_r   <= 1'b1;
      rx_filt_r   <= 1'b1;
      rx_st_r     <= asu_pkg::ASU_IDLE;
      rx_cnt_r    <= 4'h0;
      rx_idx_r    <= 3'h0;
      rx_sh_r     <= 8'h00;
      rx_pbit_r   <= 1'b0;
    end else begin
      rclk_prev_r <= pin_r[asu_pkg::PIN_RCLK];
      if (rx_tick) begin
        rx_samp_r <= rx_raw;
        if (rx_raw == rx_samp_r) rx_filt_r <= rx_raw;
        rx_st_r   <= rx_st_nxt;
        rx_cnt_r  <= rx_cnt_nxt;
        rx_idx_r  <= rx_idx_nxt;
        rx_sh_r   <= rx_sh_nxt;
        rx_pbit_r <= rx_pbit_nxt;
      end
    end
  end

  // ------------------------------------------------------------------
  // line status: hardware set wins over a clear by read
  // ------------------------------------------------------------------
  logic rx_perr, rx_ferr, rx_brk;
  assign rx_perr = lctl_r[asu_pkg::LC_PEN] &
                   (rx_pbit_r != par_of(rx_word, lctl_r));
  assign rx_ferr = ~rx_filt_r;
  assign rx_brk  = ~rx_filt_r & (rx_word == 8'h00) &
                   ~(lctl_r[asu_pkg::LC_PEN] & rx_pbit_r);
  assign lstat   = {1'b0, ~thr_full_r & (tx_st_r == asu_pkg::ASU_IDLE),
                    ~thr_full_r, brk_r, ferr_r, perr_r, ovr_r, dr_r};

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rbuf_r <= 8'h00;
      dr_r   <= 1'b0;
      ovr_r  <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      brk_r  <= 1'b0;
    end else begin
      if (rx_done) rbuf_r <= rx_word;
      dr_r   <= rx_done | (dr_r & ~rd_data);
      ovr_r  <= (rx_done & dr_r) | (ovr_r & ~rd_lstat);
      perr_r <= (rx_done & rx_perr) | (perr_r & ~rd_lstat);
      ferr_r <= (rx_done & rx_ferr) | (ferr_r & ~rd_lstat);
      brk_r  <= (rx_done & rx_brk) | (brk_r & ~rd_lstat);
    end
  end

  // ------------------------------------------------------------------
  // modem lines: order cts, dsr, ri, dcd, active high
  // ------------------------------------------------------------------
  logic [3:0] mnow, mset;
  assign mnow = loop ? {mctl_r[asu_pkg::MC_OUT2], mctl_r[asu_pkg::MC_OUT1],
                        mctl_r[asu_pkg::MC_DTR], mctl_r[asu_pkg::MC_RTS]}
                     : ~{pin_r[asu_pkg::PIN_DCD], pin_r[asu_pkg::PIN_RI],
                         pin_r[asu_pkg::PIN_DSR], pin_r[asu_pkg::PIN_CTS]};
  // the ring flag sets when the active-low pin goes low to high
  assign mset  = {mnow[3] ^ mprev_r[3], ~mnow[2] & mprev_r[2],
                  mnow[1] ^ mprev_r[1], mnow[0] ^ mprev_r[0]};
  assign mstat = {mnow[3], mnow[2], mnow[1], mnow[0],
                  mdelta_r[3], mdelta_r[2], mdelta_r[1], mdelta_r[0]};

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mprev_r  <= 4'h0;
      mdelta_r <= 4'h0;
      request_to_send_n_out    <= 1'b1;
      terminal_ready_n_out     <= 1'b1;
      general_output_one_n_out <= 1'b1;
      general_output_two_n_out <= 1'b1;
    end else begin
      mprev_r  <= mnow;
      mdelta_r <= mset | (mdelta_r & {4{~rd_mstat}});
      request_to_send_n_out    <= loop | ~mctl_r[asu_pkg::MC_RTS];
      terminal_ready_n_out     <= loop | ~mctl_r[asu_pkg::MC_DTR];
      general_output_one_n_out <= loop | ~mctl_r[asu_pkg::MC_OUT1];
      general_output_two_n_out <= loop | ~mctl_r[asu_pkg::MC_OUT2];
    end
  end

  // ------------------------------------------------------------------
  // interrupt sources and output
  // ------------------------------------------------------------------
  assign pend = {mdelta_r[3], mdelta_r[2], mdelta_r[1], mdelta_r[0],
                 brk_r, ferr_r, perr_r, ovr_r, ~thr_full_r, dr_r};
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) irq_out <= 1'b0;
    else            irq_out <= |(pend & ien_r);
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_load; tx_load; endsequence
  sequence s_start_bit; tx_st_r == asu_pkg::ASU_START && !tx_bit_r;
  endsequence
  a_tx_load_start: assert property (s_load |=> s_start_bit)
    else $error("holding data did not start a frame");
  a_tx_bit_timing: assert property (
    $changed(tx_bit_r) && !$past(tx_load) |-> $past(tx_bit_end))
    else $error("transmit bit changed off the bit boundary");
  a_thre_irq: assert property (
    !thr_full_r && ien_r[asu_pkg::IS_THRE] |=> irq_out)
    else $error("empty holding register gave no interrupt");
  a_rx_filter: assert property (
    $changed(rx_filt_r) |-> $past(rx_tick) && $past(rx_raw) == $past(rx_samp_r))
    else $error("filter passed a short pulse");
  a_rx_irq: assert property (
    rx_done && ien_r[asu_pkg::IS_RXRDY] |-> ##2 irq_out)
    else $error("received byte gave no interrupt");
  a_frame_err: assert property (
    rx_done && !rx_filt_r |=> ferr_r)
    else $error("missing stop bit not flagged");
  a_modem_out: assert property (
    !loop && $stable(mctl_r) [*2] |->
    request_to_send_n_out == !mctl_r[asu_pkg::MC_RTS])
    else $error("request to send does not follow control bit");
  a_ring_trail: assert property (
    !rd_mstat && mprev_r[2] && !mnow[2] |=> mdelta_r[2])
    else $error("ring trailing edge not flagged");
  a_loop_idle: assert property (loop |=> serial_out)
    else $error("serial output not idle in loop-back");
  a_rx_centre: assert property (
    rx_tick && rx_st_r == asu_pkg::ASU_START && rx_cnt_r == asu_pkg::SUB_HALF
    && !rx_filt_r |=> rx_st_r == asu_pkg::ASU_DATA && rx_cnt_r == 4'h0)
    else $error("start bit not confirmed at its centre");
endmodule : asu_uart

// ---- verif/asu_remote.sv ----
// remote serial device: 16x receive clock and frame sender
`timescale 1ns/100ps
module asu_remote (
  output logic rx_clk_out,
  output logic line_out
);
  initial {rx_clk_out, line_out} = 2'h1;
  always #100 rx_clk_out = ~rx_clk_out;
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      line_out = b[i];
      repeat (16) @(posedge rx_clk_out);
    end
  endtask : send
endmodule : asu_remote

// ---- verif/test_async_serial_uart.sv ----
// self-checking testbench for the asynchronous serial uart
`timescale 1ns/100ps
module test_async_serial_uart;
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0;
  logic        pwr = 1'h0, ri_n = 1'h1, cts_n = 1'h1;
  logic        ready, slverr, irq, rclk, line, rts_n, dtr_n, o1_n, o2_n;
  logic        sout, bclk_n;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  int          num_errors = 0, compares = 0, cyc = 0;
  always #12.5 clk = ~clk;
  asu_remote u_asu_remote (.rx_clk_out(rclk), .line_out(line));
  asu_uart u_asu_uart (.ref_clk_in(clk), .arst_n_in(rst_n),
    .apb_psel_in(psel), .apb_penable_in(pen), .apb_pwrite_in(pwr),
    .apb_paddr_in(addr), .apb_pwdata_in(wdat), .apb_prdata_out(rdat),
    .apb_pready_out(ready), .apb_pslverr_out(slverr), .serial_in(line),
    .rx_clock_in(rclk), .carrier_detect_n_in(1'h1), .irq_out(irq),
    .ring_indicator_n_in(ri_n), .data_set_ready_n_in(1'h1),
    .clear_to_send_n_in(cts_n), .serial_out(sout), .baud_clock_out_n(bclk_n),
    .request_to_send_n_out(rts_n), .terminal_ready_n_out(dtr_n),
    .general_output_one_n_out(o1_n), .general_output_two_n_out(o2_n));
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    {psel, pwr, addr, wdat} <= {1'h1, w, a, d};
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (ready !== 1'h1);
    {psel, pen} <= 2'h0;
    if (!w) chk({slverr, rdat[30:0]}, d);
  endtask : bus
  always @(posedge clk)
    if (++cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    bus(1'h1, asu_pkg::OFS_MCTL, 32'h0A);
    bus(1'h1, asu_pkg::OFS_SCRATCH, 32'hA5);
    bus(1'h0, asu_pkg::OFS_SCRATCH, 32'hA5);
    chk({o2_n, o1_n, rts_n, dtr_n}, 32'h5);
    chk(bclk_n, 32'h0);
    bus(1'h0, 8'h28, 32'h8000_0000);
    bus(1'h1, asu_pkg::OFS_IEN, 32'h41);
    {cts_n, ri_n} <= 2'h0;
    repeat (8) @(posedge clk);
    ri_n <= 1'h1;
    repeat (8) @(posedge clk);
    chk(irq, 32'h1);
    bus(1'h0, asu_pkg::OFS_MSTAT, 32'h15);
    bus(1'h0, asu_pkg::OFS_MSTAT, 32'h10);
    u_asu_remote.send({4'h7, 8'h5A, 1'h0}, 10);
    chk(irq, 32'h1);
    bus(1'h0, asu_pkg::OFS_LSTAT, 32'h61);
    bus(1'h0, asu_pkg::OFS_DATA, 32'h5A);
    bus(1'h1, asu_pkg::OFS_LCTL, 32'h1A);
    bus(1'h1, asu_pkg::OFS_IEN, 32'h08);
    u_asu_remote.send({4'hF, 7'h35, 1'h0}, 10);
    chk(irq, 32'h1);
    bus(1'h0, asu_pkg::OFS_LSTAT, 32'h65);
    bus(1'h0, asu_pkg::OFS_DATA, 32'h35);
    bus(1'h1, asu_pkg::OFS_MCTL, 32'h12);
    bus(1'h1, asu_pkg::OFS_DATA, 32'h35);
    repeat (40) @(posedge clk);
    chk(sout, 32'h1);
    repeat (560) @(posedge clk);
    bus(1'h0, asu_pkg::OFS_LSTAT, 32'h61);
    bus(1'h0, asu_pkg::OFS_DATA, 32'h35);
    bus(1'h1, asu_pkg::OFS_IEN, 32'h02);
    repeat (2) @(posedge clk);
    chk(irq, 32'h1);
    wrap_up();
  end
endmodule : test_async_serial_uart
